/* hw/adc_defines.vh */
/*
 * Constants for the converter control block: register offsets, field
 * positions, reset values and timing counts.
 * Assumes a 125 MHz APB clock and word-aligned 32-bit registers.
 */
`ifndef ADC_DEFINES_VH
`define ADC_DEFINES_VH

// Register byte offsets
`define ADC_OFS_CTRL 12'h000
`define ADC_OFS_STAT 12'h004
`define ADC_OFS_RESH 12'h008
`define ADC_OFS_RESL 12'h00c
`define ADC_OFS_DATA 12'h010

// Control register fields
`define ADC_CTRL_PU 7
`define ADC_CTRL_PRS_HI 3
`define ADC_CTRL_PRS_LO 0
`define ADC_CTRL_RST 8'h00

// Status/control register fields
`define ADC_STAT_CCF 7
`define ADC_STAT_IE 6
`define ADC_STAT_CH_HI 2
`define ADC_STAT_CH_LO 0
`define ADC_STAT_RST 8'h00

// Timing
`define ADC_SAMPLE_CYC 5'h0e
`define ADC_RES_BITS 10
`define ADC_SAR_CYC 4'ha

`endif

/* hw/adc_sar_seq.v */
/*
 * Conversion sequencer: sample window then bit-by-bit approximation.
 * Assumes a one-cycle conversion clock enable and an external comparator
 * whose result is valid on each conversion clock.
 */
`timescale 1ns/10ps
`include "adc_defines.vh"

module adc_sar_seq (
	input wire pclk, // Bus clock
	input wire presetn, // Async reset, low
	input wire cclk_en, // Conversion clock enable
	input wire start, // Begin conversion
	input wire abort, // Terminate conversion
	input wire comp_in, // Comparator: input above trial
	output reg sample_ff, // Sample stage active
	output reg [9:0] trial_ff, // Trial code to DAC
	output reg done_ff, // One-cycle end pulse
	output reg busy_ff // Conversion running
);

	localparam ST_IDLE = 2'h0;
	localparam ST_SAMP = 2'h1;
	localparam ST_SAR = 2'h2;

	reg [1:0] state_ff;
	reg [4:0] cnt_ff;
	reg [9:0] bit_ff;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= ST_IDLE;
			cnt_ff <= 5'h00;
			bit_ff <= 10'h000;
			trial_ff <= 10'h000;
			sample_ff <= 1'b0;
			done_ff <= 1'b0;
			busy_ff <= 1'b0;
		end else begin
			done_ff <= 1'b0;
			if (abort) begin
				state_ff <= ST_IDLE;
				sample_ff <= 1'b0;
				busy_ff <= 1'b0;
				trial_ff <= 10'h000;
			end
			if (start) begin
				state_ff <= ST_SAMP;
				cnt_ff <= 5'h00;
				sample_ff <= 1'b1;
				busy_ff <= 1'b1;
				trial_ff <= 10'h000;
			end else if (!abort && cclk_en) begin
				case (state_ff)
				ST_SAMP: begin
					if (cnt_ff == `ADC_SAMPLE_CYC - 5'h01) begin
						state_ff <= ST_SAR;
						sample_ff <= 1'b0;
						bit_ff <= 10'h200;
						trial_ff <= 10'h200;
					end else begin
						cnt_ff <= cnt_ff + 5'h01;
					end
				end
				ST_SAR: begin
					if (!comp_in)
						trial_ff <= (trial_ff & ~bit_ff) | (bit_ff >> 1);
					else
						trial_ff <= trial_ff | (bit_ff >> 1);
					bit_ff <= bit_ff >> 1;
					if (bit_ff == 10'h001) begin
						if (!comp_in)
							trial_ff <= trial_ff & ~bit_ff;
						state_ff <= ST_IDLE;
						busy_ff <= 1'b0;
						done_ff <= 1'b1;
					end
				end
				default: state_ff <= ST_IDLE;
				endcase
			end
		end
	end

endmodule

/* hw/adc_ctrl.v */
/*
 * Converter control top: APB register file, prescaler, channel mux
 * select, result capture and conversion-complete flag with interrupt.
 * Assumes an APB master on pclk and an analog front end driven by the
 * channel select, sample and trial code outputs.
 */
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/10ps
`include "adc_defines.vh"

module adc_ctrl (
	input wire pclk, // Bus clock 125 MHz
	input wire presetn, // Async reset, low
	input wire psel, // APB select
	input wire penable, // APB access phase
	input wire pwrite, // APB direction
	input wire [11:0] paddr, // APB byte address
	input wire [31:0] pwdata, // APB write data
	output wire pready, // APB ready
	output reg [31:0] prdata, // APB read data
	output wire pslverr, // APB error
	input wire comp_pin, // Comparator from analog side
	output wire [2:0] chan_sel, // Analog mux channel
	output wire [7:0] chan_onehot, // Per-channel switch enables
	output wire sample_en, // Sample stage active
	output wire [9:0] dac_code, // Trial code
	output wire power_up, // Analog power enable
	output wire conv_irq // Interrupt request, high
);

	reg [7:0] ctrl_ff;
	reg [7:0] stat_ff;
	reg ccf_ff;
	reg [9:0] result_ff;
	reg [4:0] div_ff;
	reg cclk_en_ff;
	reg comp_s1_ff;
	reg comp_s2_ff;

	wire wr_acc;
	wire rd_acc;
	wire wr_ctrl;
	wire wr_stat;
	wire rd_res;
	wire addr_ok;
	wire start;
	wire abort;
	wire done;
	wire busy;
	wire [9:0] trial;
	wire sample;
	reg [9:0] nxt_result;

	assign wr_acc = psel & penable & pwrite;
	assign rd_acc = psel & penable & ~pwrite;
	assign addr_ok = (paddr == `ADC_OFS_CTRL) | (paddr == `ADC_OFS_STAT) |
		(paddr == `ADC_OFS_RESH) | (paddr == `ADC_OFS_RESL) |
		(paddr == `ADC_OFS_DATA);
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~addr_ok;
	assign wr_ctrl = wr_acc & (paddr == `ADC_OFS_CTRL);
	assign wr_stat = wr_acc & (paddr == `ADC_OFS_STAT);
	assign rd_res = rd_acc & ((paddr == `ADC_OFS_RESH) |
		(paddr == `ADC_OFS_RESL));

	// Powered down means no new conversion can start
	assign start = wr_stat & ctrl_ff[`ADC_CTRL_PU];
	assign abort = wr_ctrl | wr_stat | ~ctrl_ff[`ADC_CTRL_PU];

	// Registers kept on power-up; only presetn initialises them
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= `ADC_CTRL_RST;
			stat_ff <= `ADC_STAT_RST;
		end else begin
			if (wr_ctrl)
				ctrl_ff <= pwdata[7:0];
			if (wr_stat)
				stat_ff <= pwdata[7:0];
		end
	end

	// Prescaler: conversion clock = pclk / (2 * (prs + 1))
	// Five bits so that 2 * 15 + 1 does not wrap
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_ff <= 5'h00;
			cclk_en_ff <= 1'b0;
		end else if (div_ff >=
			{ctrl_ff[`ADC_CTRL_PRS_HI:`ADC_CTRL_PRS_LO], 1'b1}) begin
			div_ff <= 5'h00;
			cclk_en_ff <= 1'b1;
		end else begin
			div_ff <= div_ff + 5'h01;
			cclk_en_ff <= 1'b0;
		end
	end

	// Comparator comes from the analog domain
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			comp_s1_ff <= 1'b0;
			comp_s2_ff <= 1'b0;
		end else begin
			comp_s1_ff <= comp_pin;
			comp_s2_ff <= comp_s1_ff;
		end
	end

	adc_sar_seq u_seq (
		.pclk(pclk),
		.presetn(presetn),
		.cclk_en(cclk_en_ff),
		.start(start),
		.abort(abort & ~start),
		.comp_in(comp_s2_ff),
		.sample_ff(sample),
		.trial_ff(trial),
		.done_ff(done),
		.busy_ff(busy)
	);

	always @* begin
		nxt_result = result_ff;
		if (done)
			nxt_result = trial;
	end

	// Set beats clear: a finishing conversion wins over a result read
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_ff <= 10'h000;
			ccf_ff <= 1'b0;
		end else begin
			result_ff <= nxt_result;
			if (done)
				ccf_ff <= 1'b1;
			else if (wr_stat | rd_res)
				ccf_ff <= 1'b0;
		end
	end

	always @* begin
		prdata = 32'h0000_0000;
		if (rd_acc) begin
			case (paddr)
			`ADC_OFS_CTRL: prdata = {24'h00_0000, ctrl_ff};
			`ADC_OFS_STAT: prdata = {24'h00_0000, ccf_ff,
				stat_ff[`ADC_STAT_IE], 2'h0, busy,
				stat_ff[`ADC_STAT_CH_HI:`ADC_STAT_CH_LO]};
			`ADC_OFS_RESH: prdata = {30'h0000_0000, result_ff[9:8]};
			`ADC_OFS_RESL: prdata = {24'h00_0000, result_ff[7:0]};
			`ADC_OFS_DATA: prdata = {22'h00_0000, result_ff};
			default: prdata = 32'h0000_0000;
			endcase
		end
	end

	assign chan_sel = stat_ff[`ADC_STAT_CH_HI:`ADC_STAT_CH_LO];

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_ch
			assign chan_onehot[gi] = busy & (chan_sel == gi);
		end
	endgenerate

	assign sample_en = sample;
	assign dac_code = trial;
	assign power_up = ctrl_ff[`ADC_CTRL_PU];
	// Combinational so reset drops it at once
	assign conv_irq = ccf_ff & stat_ff[`ADC_STAT_IE];

endmodule

/* tb/adc_ctrl_assertions.sv */
/*
 * Port-level checker for the converter control top.
 * Assumes bind to adc_ctrl; one clock, async active-low reset.
 */
`timescale 1ns/10ps

module adc_ctrl_chk (
	input wire pclk, // Clock
	input wire presetn, // Reset, low
	input wire psel, // Select
	input wire penable, // Access
	input wire pwrite, // Direction
	input wire [11:0] paddr, // Address
	input wire [31:0] pwdata, // Write data
	input wire pready, // Ready
	input wire [31:0] prdata, // Read data
	input wire pslverr, // Error
	input wire comp_pin, // Comparator
	input wire [2:0] chan_sel, // Channel
	input wire [7:0] chan_onehot, // Switches
	input wire sample_en, // Sampling
	input wire [9:0] dac_code, // Trial code
	input wire power_up, // Power
	input wire conv_irq // Interrupt
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire acc = psel && penable;
	wire stw = acc && pwrite && paddr == 12'h004;
	wire rdc = acc && !pwrite && (paddr == 12'h008 || paddr == 12'h00c);

	rst_idle_a: assert property ($rose(presetn) |-> !power_up && !conv_irq)
		else $error("outputs not idle after reset");
	// A result landing in the same cycle wins over the clear
	stat_clr_a: assert property (stw && !$fell(chan_onehot != 8'h00)
		|=> !conv_irq)
		else $error("status write left interrupt");
	res_clr_a: assert property (rdc && !$fell(chan_onehot != 8'h00)
		|=> !conv_irq)
		else $error("result read left interrupt");
	irq_hold_a: assert property (conv_irq && !stw && !rdc |=> conv_irq)
		else $error("interrupt dropped while flag set");
	stat_start_a: assert property (stw && power_up |=> sample_en)
		else $error("status write started nothing");
	ctrl_abort_a: assert property (acc && pwrite && paddr == 12'h000
		|=> !sample_en && chan_onehot == 8'h00)
		else $error("control write did not abort");
	// Flag sets one cycle after busy drops
	irq_end_a: assert property ($rose(conv_irq) |-> $past(chan_onehot, 2) != 0)
		else $error("interrupt rose outside conversion end");
	mux_one_a: assert property (chan_onehot != 0
		|-> chan_onehot == (8'h01 << chan_sel))
		else $error("mux not one-hot on selected channel");
	pwr_off_a: assert property (!power_up |-> !sample_en)
		else $error("sampling while powered down");

	cover property ($rose(conv_irq));
	cover property (stw && sample_en);
	cover property (rdc && conv_irq);
endmodule

bind adc_ctrl adc_ctrl_chk u_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
	.comp_pin(comp_pin), .chan_sel(chan_sel), .chan_onehot(chan_onehot),
	.sample_en(sample_en), .dac_code(dac_code), .power_up(power_up),
	.conv_irq(conv_irq));

/* tb/adc_ctrl_tb_top.sv */
/*
 * Self-checking bench for the converter control top over APB.
 * Assumes zero-wait APB slave and comparator held high (code 3ff).
 */
`timescale 1ns/10ps

module adc_ctrl_tb_top;
	logic pclk, presetn, psel, penable, pwrite, comp_pin, serr;
	logic [11:0] paddr;
	logic [31:0] pwdata, rdat;
	wire pready, pslverr, sample_en, power_up, conv_irq;
	wire [31:0] prdata;
	wire [2:0] chan_sel;
	wire [7:0] chan_onehot;
	wire [9:0] dac_code;
	int num_errors, n_tests, n, k;

	adc_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.comp_pin(comp_pin), .chan_sel(chan_sel), .chan_onehot(chan_onehot),
		.sample_en(sample_en), .dac_code(dac_code), .power_up(power_up),
		.conv_irq(conv_irq));

	initial begin
		pclk = 0;
		forever #4 pclk = ~pclk;
	end

	task finish_test;
		if (num_errors == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task chk(input string nm, input [31:0] s, input [31:0] e);
		n_tests++;
		if (s !== e) begin
			num_errors++;
			$display("unexpected %s exp %h got %h", nm, e, s);
		end
	endtask

	// Held until pready is sampled high, data taken at that edge
	task acc(input w, input [11:0] a, input [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 64);
		rdat = prdata;
		serr = pslverr;
		psel <= 0;
		penable <= 0;
		if (pready !== 1'b1) begin
			num_errors++;
			finish_test;
		end
	endtask

	task wirq;
		for (k = 0; k < 300 && conv_irq !== 1'b1; k++)
			@(posedge pclk);
		if (conv_irq !== 1'b1) begin
			num_errors++;
			finish_test;
		end
	endtask

	initial begin
		{psel, penable, pwrite, presetn, serr} = 0;
		paddr = 0;
		pwdata = 0;
		comp_pin = 1;
		num_errors = 0;
		n_tests = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1;
		acc(0, 12'h000, 0); chk("ctrl", rdat, 0);
		acc(0, 12'h020, 0); chk("unmap", {serr, rdat[30:0]}, 32'h80000000);
		acc(1, 12'h000, 32'h80);
		acc(0, 12'h000, 0); chk("ctrl", rdat, 32'h80);
		acc(1, 12'h004, 32'h45);
		@(posedge pclk);
		#1 chk("mux", chan_onehot, 8'h20);
		chk("chsel", chan_sel, 5);
		n = 1;
		repeat (100) begin
			@(posedge pclk);
			if (sample_en) n++;
		end
		// Prescaler 0: one conversion clock per two bus clocks
		chk("samp", n >= 27 && n <= 29, 1);
		chk("irq", conv_irq, 1);
		acc(0, 12'h004, 0); chk("stat", rdat, 32'hc5);
		acc(0, 12'h010, 0); chk("data", rdat, 32'h3ff);
		chk("hold", conv_irq, 1);
		acc(0, 12'h00c, 0); chk("resl", rdat, 32'hff);
		@(posedge pclk);
		#1 chk("irq", conv_irq, 0);
		acc(1, 12'h004, 32'h03);
		for (k = 0; k < 40; k++) begin
			acc(0, 12'h004, 0);
			if (rdat[7]) break;
		end
		chk("poll", rdat, 32'h83);
		chk("irq", conv_irq, 0);
		acc(0, 12'h008, 0); chk("resh", rdat, 32'h3);
		acc(0, 12'h004, 0); chk("ccf", rdat, 32'h3);
		acc(1, 12'h004, 32'h41);
		wirq;
		acc(1, 12'h004, 32'h41);
		#1 chk("irq", conv_irq, 0);
		acc(1, 12'h000, 32'h80);
		#1 chk("abort", sample_en, 0);
		acc(0, 12'h004, 0); chk("keep", rdat, 32'h41);
		acc(1, 12'h000, 32'h81);
		acc(1, 12'h004, 32'h46);
		n = 0;
		repeat (100) begin
			@(posedge pclk);
			if (sample_en) n++;
		end
		// Prescaler 1: one conversion clock per four bus clocks
		chk("samp4", n >= 53 && n <= 56, 1);
		wirq;
		@(posedge pclk);
		presetn <= 0;
		#1 chk("irq", conv_irq, 0);
		chk("sar", dac_code, 0);
		chk("pwr", power_up, 0);
		@(posedge pclk);
		presetn <= 1;
		acc(0, 12'h004, 0); chk("stat", rdat, 0);
		finish_test;
	end
endmodule
